// *** rtl/rroc_pkg.sv ***
// constants and types shared by the relay output controller
package rroc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_LOCKPWM  = 8'h04;
  localparam logic [7:0] ADDR_TON      = 8'h08;
  localparam logic [7:0] ADDR_TOFF     = 8'h0C;
  localparam logic [7:0] ADDR_THOLD    = 8'h10;
  localparam logic [7:0] ADDR_TWARN    = 8'h14;
  localparam logic [7:0] ADDR_TINTR    = 8'h18;
  localparam logic [7:0] ADDR_TCYC     = 8'h1C;
  localparam logic [7:0] ADDR_CMD      = 8'h20;
  localparam logic [7:0] ADDR_DIM      = 8'h24;
  localparam logic [7:0] ADDR_VALVE    = 8'h28;
  localparam logic [7:0] ADDR_PRIOPWM  = 8'h2C;
  localparam logic [7:0] ADDR_SCENECMD = 8'h30;
  localparam logic [7:0] ADDR_STATUS   = 8'h34;
  localparam logic [1:0] ADDR_SCENE_HI = 2'h1;

  // control register field positions
  localparam int CTRL_MODE      = 0;
  localparam int CTRL_PWRRET    = 4;
  localparam int CTRL_REPORT    = 6;
  localparam int CTRL_LOCKEN    = 8;
  localparam int CTRL_LOCKPOL   = 9;
  localparam int CTRL_LOCKSTART = 10;
  localparam int CTRL_LOCKEND   = 12;
  localparam int CTRL_VALVELOCK = 15;
  localparam int CTRL_RTRDELAY  = 16;
  localparam int CTRL_RTRSTAIR  = 17;
  localparam int CTRL_STAIROFF  = 18;
  localparam int CTRL_WARNEN    = 19;
  localparam int CTRL_WIDTH     = 20;

  // command register bit positions
  localparam int CMD_SWVAL  = 0;
  localparam int CMD_SWGO   = 1;
  localparam int CMD_STVAL  = 2;
  localparam int CMD_STGO   = 3;
  localparam int CMD_LKVAL  = 4;
  localparam int CMD_LKGO   = 5;
  localparam int CMD_PRVAL  = 6;
  localparam int CMD_PRGO   = 7;
  localparam int CMD_READ   = 8;
  localparam int CMD_REBOOT = 9;
  localparam int SCENE_LEARN = 7;

  // reset values
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 20'h00002;
  localparam logic [15:0]           TIME_RESET = 16'h000A;

  // timer tick: 1 ms at 200 MHz
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned TICK_NS       = 1000000;
  localparam int unsigned TICK_CYCLES   = (TICK_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    RROC_DISABLED  = 3'h0,
    RROC_DIMSUPPLY = 3'h1,
    RROC_UNIVERSAL = 3'h2,
    RROC_DELAY     = 3'h3,
    RROC_STAIR     = 3'h4,
    RROC_VALVE     = 3'h5
  } rroc_mode_t;

  // shared encoding of power-return, lock start/end and scene actions
  typedef enum logic [2:0] {
    RROC_ACT_NONE  = 3'h0,
    RROC_ACT_ON    = 3'h1,
    RROC_ACT_OFF   = 3'h2,
    RROC_ACT_PRIOR = 3'h3,
    RROC_ACT_TRACK = 3'h4
  } rroc_act_t;

  typedef enum logic [1:0] {
    RROC_REP_OFF    = 2'h0,
    RROC_REP_READ   = 2'h1,
    RROC_REP_CHANGE = 2'h2,
    RROC_REP_CYCLIC = 2'h3
  } rroc_rep_t;

endpackage : rroc_pkg

// *** rtl/rroc_relay_output_controller.sv ***
// relay output controller with apb register access
//
// Functional notes
// - restart applies configured power-return action
// - four state reporting settings supported
// - cyclic mode resends state every period
// - report relay bit and valve pwm byte
// - normal switching ignored while lock active
// - priority input sets output despite lock
// - valve lock end applies last normal value
// - lock polarity selects engaging value
// - lock start applies none, on or off
// - lock end applies none/on/off/pre-lock state
// - tracked release applies last locked command
// - valve lock keeps or forces pwm level
// - dimmer supply relay follows level nonzero
// - sixteen scenes, learn stores present state
// - separate on and off switching delays
// - retrigger restarts matching delay timer
// - staircase on, auto off after hold
// - staircase retrigger restarts hold timer
// - staircase off command acted or ignored
// - prewarning before off unless disabled/too long
// - prewarning is short off interrupt
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps

module rroc_relay_output_controller #(
  parameter int unsigned TICK_CYCLES = rroc_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        sys_rst,
  // apb slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // output stage
  output logic              relayOut,
  output logic [7:0]        pwmLevel,
  // state telegrams
  output logic              stateTx,
  output logic              stateBit,
  output logic [7:0]        stateByte
);

  typedef struct packed {
    logic                               pready;
    logic                               pslverr;
    logic [31:0]                        prdata;
    logic [rroc_pkg::CTRL_WIDTH-1:0]    ctrl;
    logic [7:0]                         lockPwm;
    logic [15:0]                        tOn;
    logic [15:0]                        tOff;
    logic [15:0]                        tHold;
    logic [15:0]                        tWarn;
    logic [15:0]                        tIntr;
    logic [15:0]                        tCyc;
    logic [15:0][7:0]                   sceneCfg;
    logic [15:0]                        learned;
    logic                               booted;
    logic [31:0]                        presc;
    logic                               relay;
    logic [7:0]                         pwm;
    logic [7:0]                         lastNormal;
    logic                               locked;
    logic                               trackCmd;
    logic                               preLock;
    logic                               delayPend;
    logic                               delayVal;
    logic [15:0]                        delayCnt;
    logic                               stairRun;
    logic [15:0]                        stairCnt;
    logic                               warnDone;
    logic                               intrRun;
    logic [15:0]                        intrCnt;
    logic [15:0]                        cycCnt;
    logic                               prevRelay;
    logic [7:0]                         prevPwm;
    logic                               stateTx;
    logic                               stateBit;
    logic [7:0]                         stateByte;
  } rroc_state_t;

  rroc_state_t s;
  rroc_state_t next_s;

  always_comb begin
    logic                    tick;
    logic                    acc;
    logic                    wr;
    logic                    hit;
    logic [31:0]             rd;
    logic [31:0]             cmd;
    logic                    dimWr;
    logic                    valveWr;
    logic                    prioWr;
    logic                    sceneWr;
    logic                    lockActive;
    logic                    change;
    logic                    cycFire;
    logic                    swGo;
    logic                    swVal;
    rroc_pkg::rroc_mode_t    mode;
    rroc_pkg::rroc_act_t     act;
    rroc_pkg::rroc_rep_t     rep;
    tick       = 1'b0;
    acc        = 1'b0;
    wr         = 1'b0;
    hit        = 1'b0;
    rd         = 32'h0;
    cmd        = 32'h0;
    dimWr      = 1'b0;
    valveWr    = 1'b0;
    prioWr     = 1'b0;
    sceneWr    = 1'b0;
    lockActive = 1'b0;
    change     = 1'b0;
    cycFire    = 1'b0;
    swGo       = 1'b0;
    swVal      = 1'b0;
    act        = rroc_pkg::RROC_ACT_NONE;
    next_s     = s;
    next_s.stateTx = 1'b0;
    mode = rroc_pkg::rroc_mode_t'(s.ctrl[rroc_pkg::CTRL_MODE +: 3]);
    rep  = rroc_pkg::rroc_rep_t'(s.ctrl[rroc_pkg::CTRL_REPORT +: 2]);

    // common tick prescaler
    tick = (s.presc == 32'(TICK_CYCLES - 1));
    next_s.presc = tick ? 32'h0 : s.presc + 32'h1;

    // apb: one wait state, then pready
    acc = psel & penable;
    wr  = acc & pwrite & s.pready;
    next_s.pready = acc & ~s.pready;
    hit = 1'b1;
    if (paddr == rroc_pkg::ADDR_CTRL) begin
      rd = 32'(s.ctrl);
    end else if (paddr == rroc_pkg::ADDR_LOCKPWM) begin
      rd = 32'(s.lockPwm);
    end else if (paddr == rroc_pkg::ADDR_TON) begin
      rd = 32'(s.tOn);
    end else if (paddr == rroc_pkg::ADDR_TOFF) begin
      rd = 32'(s.tOff);
    end else if (paddr == rroc_pkg::ADDR_THOLD) begin
      rd = 32'(s.tHold);
    end else if (paddr == rroc_pkg::ADDR_TWARN) begin
      rd = 32'(s.tWarn);
    end else if (paddr == rroc_pkg::ADDR_TINTR) begin
      rd = 32'(s.tIntr);
    end else if (paddr == rroc_pkg::ADDR_TCYC) begin
      rd = 32'(s.tCyc);
    end else if (paddr == rroc_pkg::ADDR_CMD || paddr == rroc_pkg::ADDR_DIM ||
                 paddr == rroc_pkg::ADDR_SCENECMD) begin
      rd = 32'h0;
    end else if (paddr == rroc_pkg::ADDR_VALVE) begin
      rd = 32'(s.lastNormal);
    end else if (paddr == rroc_pkg::ADDR_PRIOPWM) begin
      rd = 32'h0;
    end else if (paddr == rroc_pkg::ADDR_STATUS) begin
      rd = {15'h0, s.intrRun, s.pwm, 5'h0, s.stairRun, s.locked, s.relay};
    end else if (paddr[7:6] == rroc_pkg::ADDR_SCENE_HI && paddr[1:0] == 2'h0) begin
      rd = {15'h0, s.learned[paddr[5:2]], 8'h0, s.sceneCfg[paddr[5:2]]};
    end else begin
      hit = 1'b0;
    end
    if (acc & ~s.pready) begin
      next_s.prdata  = pwrite ? 32'h0 : rd;
      next_s.pslverr = ~hit;
    end

    // register writes
    if (wr & hit) begin
      if (paddr == rroc_pkg::ADDR_CTRL) begin
        next_s.ctrl = pwdata[rroc_pkg::CTRL_WIDTH-1:0];
      end else if (paddr == rroc_pkg::ADDR_LOCKPWM) begin
        next_s.lockPwm = pwdata[7:0];
      end else if (paddr == rroc_pkg::ADDR_TON) begin
        next_s.tOn = pwdata[15:0];
      end else if (paddr == rroc_pkg::ADDR_TOFF) begin
        next_s.tOff = pwdata[15:0];
      end else if (paddr == rroc_pkg::ADDR_THOLD) begin
        next_s.tHold = pwdata[15:0];
      end else if (paddr == rroc_pkg::ADDR_TWARN) begin
        next_s.tWarn = pwdata[15:0];
      end else if (paddr == rroc_pkg::ADDR_TINTR) begin
        next_s.tIntr = pwdata[15:0];
      end else if (paddr == rroc_pkg::ADDR_TCYC) begin
        next_s.tCyc = pwdata[15:0];
      end else if (paddr == rroc_pkg::ADDR_CMD) begin
        cmd = pwdata;
      end else if (paddr == rroc_pkg::ADDR_DIM) begin
        dimWr = 1'b1;
      end else if (paddr == rroc_pkg::ADDR_VALVE) begin
        valveWr = 1'b1;
      end else if (paddr == rroc_pkg::ADDR_PRIOPWM) begin
        prioWr = 1'b1;
      end else if (paddr == rroc_pkg::ADDR_SCENECMD) begin
        sceneWr = 1'b1;
      end else if (paddr[7:6] == rroc_pkg::ADDR_SCENE_HI) begin
        next_s.sceneCfg[paddr[5:2]] = pwdata[7:0];
      end
    end

    swGo  = cmd[rroc_pkg::CMD_SWGO];
    swVal = cmd[rroc_pkg::CMD_SWVAL];

    if (cmd[rroc_pkg::CMD_REBOOT]) begin
      // soft restart: clear timers and lock, relay stays bistable
      next_s.booted    = 1'b0;
      next_s.presc     = 32'h0;
      next_s.locked    = 1'b0;
      next_s.delayPend = 1'b0;
      next_s.stairRun  = 1'b0;
      next_s.intrRun   = 1'b0;
      next_s.cycCnt    = 16'h0;
    end else if (!s.booted) begin
      // power return action
      next_s.booted = 1'b1;
      act = rroc_pkg::rroc_act_t'({1'b0, s.ctrl[rroc_pkg::CTRL_PWRRET +: 2]});
      case (act)
        rroc_pkg::RROC_ACT_ON: begin
          next_s.relay = 1'b1;
        end
        rroc_pkg::RROC_ACT_OFF: begin
          next_s.relay = 1'b0;
        end
        rroc_pkg::RROC_ACT_PRIOR: begin
          next_s.relay = s.prevRelay;
          next_s.pwm   = s.lastNormal;
        end
        default: begin
          next_s.relay = s.relay;
        end
      endcase
      next_s.trackCmd = next_s.relay;
    end else begin
      // lock handling
      if (cmd[rroc_pkg::CMD_LKGO] && s.ctrl[rroc_pkg::CTRL_LOCKEN]) begin
        lockActive = s.ctrl[rroc_pkg::CTRL_LOCKPOL] ? cmd[rroc_pkg::CMD_LKVAL]
                                                    : ~cmd[rroc_pkg::CMD_LKVAL];
        if (lockActive && !s.locked) begin
          next_s.locked   = 1'b1;
          next_s.preLock  = s.relay;
          next_s.trackCmd = s.relay;
          if (mode == rroc_pkg::RROC_VALVE) begin
            if (s.ctrl[rroc_pkg::CTRL_VALVELOCK]) begin
              next_s.pwm = s.lockPwm;
            end
          end else begin
            act = rroc_pkg::rroc_act_t'({1'b0, s.ctrl[rroc_pkg::CTRL_LOCKSTART +: 2]});
            if (act == rroc_pkg::RROC_ACT_ON) begin
              next_s.relay = 1'b1;
            end else if (act == rroc_pkg::RROC_ACT_OFF) begin
              next_s.relay = 1'b0;
            end
          end
        end else if (!lockActive && s.locked) begin
          next_s.locked = 1'b0;
          if (mode == rroc_pkg::RROC_VALVE) begin
            next_s.pwm = s.lastNormal;
          end else begin
            act = rroc_pkg::rroc_act_t'(s.ctrl[rroc_pkg::CTRL_LOCKEND +: 3]);
            case (act)
              rroc_pkg::RROC_ACT_ON: begin
                next_s.relay = 1'b1;
              end
              rroc_pkg::RROC_ACT_OFF: begin
                next_s.relay = 1'b0;
              end
              rroc_pkg::RROC_ACT_PRIOR: begin
                next_s.relay = s.preLock;
              end
              rroc_pkg::RROC_ACT_TRACK: begin
                next_s.relay = s.trackCmd;
              end
              default: begin
                next_s.relay = s.relay;
              end
            endcase
          end
        end
      end

      // normal switching, blocked while locked
      if (s.locked) begin
        if (swGo) begin
          next_s.trackCmd = swVal;
        end
      end else begin
        case (mode)
          rroc_pkg::RROC_UNIVERSAL: begin
            if (swGo) begin
              next_s.relay = swVal;
            end
          end
          rroc_pkg::RROC_DELAY: begin
            if (swGo && (!s.delayPend || s.delayVal != swVal ||
                         s.ctrl[rroc_pkg::CTRL_RTRDELAY])) begin
              next_s.delayPend = 1'b1;
              next_s.delayVal  = swVal;
              next_s.delayCnt  = swVal ? s.tOn : s.tOff;
            end
          end
          rroc_pkg::RROC_STAIR: begin
            if (swGo) begin
              next_s.relay    = swVal;
              next_s.stairRun = 1'b0;
              next_s.intrRun  = 1'b0;
            end
            if (cmd[rroc_pkg::CMD_STGO]) begin
              if (cmd[rroc_pkg::CMD_STVAL]) begin
                if (!s.stairRun || s.ctrl[rroc_pkg::CTRL_RTRSTAIR]) begin
                  next_s.relay    = 1'b1;
                  next_s.stairRun = 1'b1;
                  next_s.stairCnt = s.tHold;
                  next_s.warnDone = 1'b0;
                  next_s.intrRun  = 1'b0;
                end
              end else if (s.ctrl[rroc_pkg::CTRL_STAIROFF]) begin
                next_s.relay    = 1'b0;
                next_s.stairRun = 1'b0;
                next_s.intrRun  = 1'b0;
              end
            end
          end
          rroc_pkg::RROC_VALVE: begin
            if (valveWr) begin
              next_s.pwm = pwdata[7:0];
            end
          end
          rroc_pkg::RROC_DIMSUPPLY: begin
            if (dimWr) begin
              next_s.relay = (pwdata[7:0] != 8'h00);
            end
          end
          default: begin
            next_s.relay = s.relay;
          end
        endcase
        // scene recall and learn
        if (sceneWr && mode != rroc_pkg::RROC_VALVE && mode != rroc_pkg::RROC_DISABLED) begin
          for (int i = 0; i < 16; i++) begin
            if (s.sceneCfg[i][7:2] == pwdata[5:0]) begin
              act = rroc_pkg::rroc_act_t'({1'b0, s.sceneCfg[i][1:0]});
              if (pwdata[rroc_pkg::SCENE_LEARN]) begin
                if (act == rroc_pkg::RROC_ACT_PRIOR) begin
                  next_s.learned[i] = s.relay;
                end
              end else if (act == rroc_pkg::RROC_ACT_ON) begin
                next_s.relay = 1'b1;
              end else if (act == rroc_pkg::RROC_ACT_OFF) begin
                next_s.relay = 1'b0;
              end else if (act == rroc_pkg::RROC_ACT_PRIOR) begin
                next_s.relay = s.learned[i];
              end
            end
          end
        end
      end
      if (valveWr) begin
        next_s.lastNormal = pwdata[7:0];
      end

      // timers advance on the common tick
      if (tick && s.delayPend && mode == rroc_pkg::RROC_DELAY) begin
        if (s.delayCnt == 16'h0) begin
          next_s.relay     = s.delayVal;
          next_s.delayPend = 1'b0;
        end else begin
          next_s.delayCnt = s.delayCnt - 16'h1;
        end
      end
      if (tick && s.stairRun && mode == rroc_pkg::RROC_STAIR) begin
        if (s.stairCnt == 16'h0) begin
          next_s.relay    = 1'b0;
          next_s.stairRun = 1'b0;
          next_s.intrRun  = 1'b0;
        end else begin
          next_s.stairCnt = s.stairCnt - 16'h1;
          if (s.ctrl[rroc_pkg::CTRL_WARNEN] && s.tWarn <= s.tHold && !s.warnDone &&
              s.stairCnt == s.tWarn) begin
            next_s.warnDone = 1'b1;
            next_s.relay    = 1'b0;
            next_s.intrRun  = 1'b1;
            next_s.intrCnt  = s.tIntr;
          end else if (s.intrRun) begin
            if (s.intrCnt == 16'h0) begin
              next_s.relay   = 1'b1;
              next_s.intrRun = 1'b0;
            end else begin
              next_s.intrCnt = s.intrCnt - 16'h1;
            end
          end
        end
      end

      // priority input overrides regardless of lock
      if (cmd[rroc_pkg::CMD_PRGO] && mode != rroc_pkg::RROC_VALVE) begin
        next_s.relay     = cmd[rroc_pkg::CMD_PRVAL];
        next_s.delayPend = 1'b0;
        next_s.stairRun  = 1'b0;
        next_s.intrRun   = 1'b0;
      end
      if (prioWr && mode == rroc_pkg::RROC_VALVE) begin
        next_s.pwm = pwdata[7:0];
      end
    end

    // state reporting
    change = (s.relay != s.prevRelay) ||
             (mode == rroc_pkg::RROC_VALVE && s.pwm != s.prevPwm);
    next_s.prevRelay = s.relay;
    next_s.prevPwm   = s.pwm;
    if (rep == rroc_pkg::RROC_REP_CYCLIC && s.booted) begin
      if (tick) begin
        if (s.cycCnt >= s.tCyc) begin
          cycFire       = 1'b1;
          next_s.cycCnt = 16'h0;
        end else begin
          next_s.cycCnt = s.cycCnt + 16'h1;
        end
      end
    end else begin
      next_s.cycCnt = 16'h0;
    end
    if ((change && (rep == rroc_pkg::RROC_REP_CHANGE || rep == rroc_pkg::RROC_REP_CYCLIC)) ||
        cycFire ||
        (cmd[rroc_pkg::CMD_READ] && rep != rroc_pkg::RROC_REP_OFF)) begin
      next_s.stateTx   = 1'b1;
      next_s.stateBit  = s.relay;
      next_s.stateByte = (mode == rroc_pkg::RROC_VALVE) ? s.pwm : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s          <= '0;
      s.ctrl     <= rroc_pkg::CTRL_RESET;
      s.tOn      <= rroc_pkg::TIME_RESET;
      s.tOff     <= rroc_pkg::TIME_RESET;
      s.tHold    <= rroc_pkg::TIME_RESET;
      s.tWarn    <= rroc_pkg::TIME_RESET;
      s.tIntr    <= rroc_pkg::TIME_RESET;
      s.tCyc     <= rroc_pkg::TIME_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign pready    = s.pready;
  assign prdata    = s.prdata;
  assign pslverr   = s.pslverr;
  assign relayOut  = s.relay;
  assign pwmLevel  = s.pwm;
  assign stateTx   = s.stateTx;
  assign stateBit  = s.stateBit;
  assign stateByte = s.stateByte;

endmodule : rroc_relay_output_controller

// *** verification/rroc_assertions.sv ***
// port-level assertion checker for the relay output controller
`timescale 1ns/1ps
module rroc_assertions #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // clock and reset
  input logic        clk,
  input logic        sys_rst,
  // apb
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  // outputs
  input logic        relayOut,
  input logic [7:0]  pwmLevel,
  input logic        stateTx,
  input logic        stateBit,
  input logic [7:0]  stateByte
);
  logic [7:0] ctl;
  wire        done  = psel && penable && pready;
  wire        wr    = done && pwrite;
  wire        dimNz = |pwdata[7:0];
  wire [7:0]  wLow  = pwdata[7:0];
  wire        unmap = |paddr[1:0] || (paddr > 8'h34 && (paddr < 8'h40 || paddr > 8'h7C));
  // shadow of mode, power return and report fields
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl <= rroc_pkg::CTRL_RESET[7:0];
    end else if (wr && paddr == rroc_pkg::ADDR_CTRL) begin
      ctl <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence
  property p_ready; s_setup ##1 s_wait |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("apb answer late");
  property p_err; done |-> pslverr == unmap; endproperty
  a_err: assert property (p_err) else $error("apb error flag wrong");
  property p_dim; wr && paddr == rroc_pkg::ADDR_DIM && ctl[2:0] == 3'h1
    |=> relayOut == $past(dimNz); endproperty
  a_dim: assert property (p_dim) else $error("supply relay wrong");
  property p_prio; wr && paddr == rroc_pkg::ADDR_PRIOPWM && ctl[2:0] == 3'h5
    |=> pwmLevel == $past(wLow); endproperty
  a_prio: assert property (p_prio) else $error("priority pwm wrong");
  property p_bit; stateTx |-> stateBit == $past(relayOut); endproperty
  a_bit: assert property (p_bit) else $error("telegram bit wrong");
  property p_byte; stateTx && ctl[2:0] != 3'h5 |-> stateByte == 8'h00; endproperty
  a_byte: assert property (p_byte) else $error("telegram byte wrong");
  property p_chg; $changed(relayOut) && ctl[7] |-> ##1 stateTx; endproperty
  a_chg: assert property (p_chg) else $error("change not reported");
  property p_pwr; wr && paddr == rroc_pkg::ADDR_CMD && pwdata[9] && ctl[5:4] == 2'h1
    |-> ##[1:4] relayOut; endproperty
  a_pwr: assert property (p_pwr) else $error("power return not applied");
endmodule : rroc_assertions

bind rroc_relay_output_controller rroc_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_rroc_assertions (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .relayOut(relayOut), .pwmLevel(pwmLevel), .stateTx(stateTx), .stateBit(stateBit),
  .stateByte(stateByte));

// *** verification/rroc_bus_peer.sv ***
// bus peer that collects state telegrams
`timescale 1ns/1ps
module rroc_bus_peer (
  // clock
  input logic       clk,
  // telegrams
  input logic       stateTx,
  input logic       stateBit,
  input logic [7:0] stateByte
);
  int         txCount = 0;
  logic       lastBit = 1'b0;
  logic [7:0] lastByte = 8'h00;
  // latch each telegram as received
  always @(posedge clk) begin
    if (stateTx === 1'b1) begin
      txCount  <= txCount + 1;
      lastBit  <= stateBit;
      lastByte <= stateByte;
    end
  end
endmodule : rroc_bus_peer

// *** verification/tb_relay_output_controller.sv ***
// self-checking bench for the relay output controller
`timescale 1ns/1ps
module tb_relay_output_controller;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, relayOut, stateTx, stateBit, err;
  logic [31:0] prdata, rd;
  logic [7:0]  pwmLevel, stateByte;
  int          miscompares = 0;
  int          checks_done = 0;
  always #2.5 clk = ~clk;
  rroc_relay_output_controller #(.TICK_CYCLES(4)) i_rroc_relay_output_controller (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .relayOut(relayOut), .pwmLevel(pwmLevel), .stateTx(stateTx), .stateBit(stateBit),
    .stateByte(stateByte));
  rroc_bus_peer i_rroc_bus_peer (.clk(clk), .stateTx(stateTx), .stateBit(stateBit),
    .stateByte(stateByte));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) miscompares++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [31:0] d);
    apb(1'b1, rroc_pkg::ADDR_CMD, d);
  endtask : cmd
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, rroc_pkg::ADDR_CTRL, d);
  endtask : ctl
  task automatic at(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : at
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic t_regs;
    apb(1'b0, rroc_pkg::ADDR_TCYC, 32'h0);
    chk(rd, 32'(rroc_pkg::TIME_RESET));
    apb(1'b0, 8'h38, 32'h0);
    chk(32'(err), 32'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_lock;
    ctl(32'h0000_4182);
    cmd(32'h3);
    at(4);
    chk(32'(i_rroc_bus_peer.lastBit), 32'h1);
    cmd(32'h20);
    cmd(32'h2);
    at(2);
    chk(32'(relayOut), 32'h1);
    cmd(32'h30);
    at(2);
    chk(32'(relayOut), 32'h0);
    cmd(32'h20);
    cmd(32'hC0);
    at(2);
    chk(32'(relayOut), 32'h1);
    cmd(32'h30);
    $display("test lock done");
  endtask : t_lock
  task automatic t_delay;
    ctl(32'h3);
    apb(1'b1, rroc_pkg::ADDR_TON, 32'h2);
    apb(1'b1, rroc_pkg::ADDR_TOFF, 32'h1);
    cmd(32'h2);
    at(20);
    chk(32'(relayOut), 32'h0);
    cmd(32'h3);
    at(4);
    chk(32'(relayOut), 32'h0);
    at(16);
    chk(32'(relayOut), 32'h1);
    $display("test delay done");
  endtask : t_delay
  task automatic t_stair;
    ctl(32'h4);
    apb(1'b1, rroc_pkg::ADDR_THOLD, 32'h3);
    cmd(32'h2);
    at(20);
    cmd(32'hC);
    at(3);
    chk(32'(relayOut), 32'h1);
    at(25);
    chk(32'(relayOut), 32'h0);
    $display("test stair done");
  endtask : t_stair
  task automatic t_dim;
    ctl(32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, rroc_pkg::ADDR_DIM, 32'(i % 2 * 5));
      at(1);
      chk(32'(relayOut), 32'(i % 2));
    end
    $display("test dim done");
  endtask : t_dim
  task automatic t_valve;
    ctl(32'h305);
    apb(1'b1, rroc_pkg::ADDR_VALVE, 32'h40);
    cmd(32'h30);
    at(1);
    chk(32'(pwmLevel), 32'h40);
    apb(1'b1, rroc_pkg::ADDR_PRIOPWM, 32'h80);
    at(1);
    chk(32'(pwmLevel), 32'h80);
    cmd(32'h20);
    at(2);
    chk(32'(pwmLevel), 32'h40);
    $display("test valve done");
  endtask : t_valve
  task automatic t_restart;
    int c;
    ctl(32'h12);
    cmd(32'h2);
    at(2);
    cmd(32'h200);
    at(4);
    chk(32'(relayOut), 32'h1);
    ctl(32'hC2);
    apb(1'b1, rroc_pkg::ADDR_TCYC, 32'h2);
    c = i_rroc_bus_peer.txCount;
    at(40);
    c = i_rroc_bus_peer.txCount - c;
    chk(32'(c >= 3 && c <= 4), 32'h1);
    $display("test restart done");
  endtask : t_restart
  task automatic t_scene;
    ctl(32'h2);
    cmd(32'h3);
    apb(1'b1, 8'h40, 32'hF);
    apb(1'b1, rroc_pkg::ADDR_SCENECMD, 32'h83);
    cmd(32'h2);
    apb(1'b1, rroc_pkg::ADDR_SCENECMD, 32'h3);
    at(1);
    chk(32'(relayOut), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0001000F);
    $display("test scene done");
  endtask : t_scene
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_lock;
    t_delay;
    t_stair;
    t_dim;
    t_valve;
    t_restart;
    t_scene;
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule : tb_relay_output_controller
